//--- verilog/hbdi_consts.vh
// Notes on behaviour
// - Acknowledge a register write only after select and write strobe low, synchronised.
// - Hold that acknowledge off until any running local or remote transfer ends.
// - Select may come before or after the strobe; delay counts from the later.
// - Grant must be present at T1 after request; otherwise start slips four clocks.
// - One bus transfer per grant for remote work, bursts for local work.
// - In 32-bit mode the primed address states precede only a burst's first transfer.
// - Byte bursts keep upper address lines driven; release after the last transfer.
// - Wait input sampled in T3; wait states inserted while it stays asserted.
// - Remote read: port request rises after port write strobe, drops after acknowledge high.
// - Next remote port transfer timed from acknowledge, after any pending local work.
`ifndef HBDI_CONSTS_VH
`define HBDI_CONSTS_VH
`define HBDI_SLIP_CLKS   3'h4
`define HBDI_PRIME_CLKS  3'h4
`define HBDI_ACK_SYNC    2'h2
`define HBDI_ADDR_RST    16'h0000
`define HBDI_DATA_RST    32'h00000000
`define HBDI_STEP_BYTE   16'h0001
`define HBDI_STEP_WORD   16'h0002
`define HBDI_STEP_DWORD  16'h0004
`endif

//--- verilog/hbdi_fifo.v
module hbdi_fifo #(
  parameter W  = 32,
  parameter D  = 16,
  parameter AW = 4
) (
  input  wire          clk,
  input  wire          rst,
  input  wire [W-1:0]  in_data,
  input  wire          in_valid,
  output wire          in_ready,
  output reg  [W-1:0]  out_data,
  output wire          out_valid,
  input  wire          out_ready
);
  reg  [W-1:0] mem_r [0:D-1];
  reg  [AW-1:0] wp_r;
  reg  [AW-1:0] rp_r;
  reg  [AW:0]   cnt_r;
  wire          push;
  wire          pop;

  // Honest full and empty flags
  assign in_ready  = (cnt_r != D[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Pointers and fill count
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wp_r <= (wp_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
      if (pop)
        rp_r <= (rp_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
      if (push & ~pop)
        cnt_r <= cnt_r + 1'b1;
      else if (pop & ~push)
        cnt_r <= cnt_r - 1'b1;
    end
  end

  // Storage, no reset needed
  always @(posedge clk) begin
    if (push)
      mem_r[wp_r] <= in_data;
  end

  // Head word read straight from storage
  always @* begin
    out_data = mem_r[rp_r];
  end
endmodule // hbdi_fifo

//--- verilog/hbdi_slave_ack.v
`include "hbdi_consts.vh"
module hbdi_slave_ack (
  input  wire       clk,
  input  wire       rst,
  input  wire       cs_n,
  input  wire       swr_n,
  input  wire       ras,
  input  wire [3:0] rsel,
  input  wire [7:0] wdata,
  input  wire       dma_busy,
  output reg        ack_n,
  output reg        wr_pulse,
  output reg  [3:0] wr_addr,
  output reg  [7:0] wr_data
);
  reg  [3:0] sel_lat_r;
  reg  [1:0] sync_r;
  wire       acc;
  wire [3:0] sel_now;

  assign acc = ~cs_n & ~swr_n;
  // Latch closes when strobe low; flows through while high
  assign sel_now = ras ? rsel : sel_lat_r;

  always @(posedge clk or posedge rst) begin
    if (rst)
      sel_lat_r <= 4'h0;
    else if (ras)
      sel_lat_r <= rsel;
  end

  // Access sync, then ack once no transfer runs
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_r   <= 2'h0;
      ack_n    <= 1'b1;
      wr_pulse <= 1'b0;
      wr_addr  <= 4'h0;
      wr_data  <= 8'h00;
    end else begin
      wr_pulse <= 1'b0;
      if (!acc) begin
        sync_r <= 2'h0;
        ack_n  <= 1'b1;
      end else if (sync_r != `HBDI_ACK_SYNC) begin
        sync_r <= sync_r + 2'h1;
      end else if (ack_n && !dma_busy) begin
        ack_n    <= 1'b0;
        wr_pulse <= 1'b1;
        wr_addr  <= sel_now;
        wr_data  <= wdata;
      end
    end
  end
endmodule // hbdi_slave_ack

//--- verilog/hbdi_top.v
`include "hbdi_consts.vh"
module hbdi_top #(
  parameter DW = 32
) (
  input  wire          CLK,
  input  wire          RST,
  input  wire          CS_N,
  input  wire          SLAVE_WRITE_STROBE_N,
  input  wire [3:0]    REGISTER_SELECT_LINES,
  input  wire          ADDRESS_LATCH_STROBE_IN,
  input  wire [7:0]    REG_DATA_IN,
  output wire          ACK_N,
  output wire          REG_WR_PULSE,
  output wire [3:0]    REG_WR_ADDR,
  output wire [7:0]    REG_WR_DATA,
  input  wire          BYTE_MODE,
  input  wire          WORD32_MODE,
  input  wire          LOCAL_START,
  input  wire          LOCAL_TO_MEM,
  input  wire [15:0]   LOCAL_ADDR,
  input  wire [7:0]    LOCAL_COUNT,
  input  wire          REMOTE_START,
  input  wire [15:0]   REMOTE_ADDR,
  input  wire [7:0]    REMOTE_COUNT,
  output wire          LOCAL_BUSY,
  output wire          REMOTE_BUSY,
  input  wire [DW-1:0] NET_DATA,
  input  wire          NET_VALID,
  output wire          NET_READY,
  output reg  [DW-1:0] NET_RD_DATA,
  output reg           NET_RD_VALID,
  output reg           BUS_REQUEST_OUT,
  input  wire          BUS_GRANT,
  output reg           ADDRESS_STROBE_OUT,
  output reg  [15:0]   ADDR_OUT,
  output reg           LOWER_ADDR_OE,
  output reg           UPPER_ADDRESS_LINES_OE,
  output reg  [DW-1:0] DATA_OUT,
  output reg           DATA_OE,
  input  wire [DW-1:0] DATA_IN,
  output reg           READ_STROBE_N,
  output reg           WRITE_STROBE_N,
  input  wire          EXT_WAIT,
  output reg  [DW-1:0] PORT_DATA,
  output reg           PORT_WRITE_STROBE_N,
  output reg           PORT_TRANSFER_REQUEST,
  input  wire          READ_ACK_N
);
  localparam S_IDLE  = 11'h001;
  localparam S_REQ   = 11'h002;
  localparam S_SLIP  = 11'h004;
  localparam S_PRIME = 11'h008;
  localparam S_T1    = 11'h010;
  localparam S_T2    = 11'h020;
  localparam S_T3    = 11'h040;
  localparam S_TW    = 11'h080;
  localparam S_T4    = 11'h100;
  localparam S_PWR   = 11'h200;
  localparam S_PACK  = 11'h400;

  reg  [10:0]   st_r;
  reg  [10:0]   st_nxt;
  reg  [2:0]    cnt_r;
  reg           loc_act_r;
  reg           rem_act_r;
  reg           is_loc_r;
  reg           first_r;
  reg           rack_low_r;
  reg  [15:0]   loc_addr_r;
  reg  [15:0]   rem_addr_r;
  reg  [7:0]    loc_cnt_r;
  reg  [7:0]    rem_cnt_r;
  reg  [DW-1:0] rd_data_r;
  wire [DW-1:0] fifo_data;
  wire          fifo_valid;
  wire          fifo_pop;
  wire          mem_write;
  wire          more;
  wire [15:0]   step;
  wire          dma_busy;

  // Address step per transfer width
  function [15:0] step_of;
    input byte_m;
    input w32_m;
    begin
      if (byte_m)
        step_of = `HBDI_STEP_BYTE;
      else if (w32_m)
        step_of = `HBDI_STEP_DWORD;
      else
        step_of = `HBDI_STEP_WORD;
    end
  endfunction

  assign step      = step_of(BYTE_MODE, WORD32_MODE);
  assign mem_write = is_loc_r & LOCAL_TO_MEM;
  assign more      = (loc_cnt_r != 8'h01) & (~mem_write | fifo_valid);
  assign fifo_pop  = (st_r == S_T4) & mem_write;
  assign dma_busy  = (st_r != S_IDLE);
  assign LOCAL_BUSY  = loc_act_r;
  assign REMOTE_BUSY = rem_act_r;

  // Receive data waits here for the bus
  hbdi_fifo #(
    .W  (DW),
    .D  (16),
    .AW (4)
  ) u_fifo (
    .clk       (CLK),
    .rst       (RST),
    .in_data   (NET_DATA),
    .in_valid  (NET_VALID),
    .in_ready  (NET_READY),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // Register write acknowledge
  hbdi_slave_ack u_slave (
    .clk      (CLK),
    .rst      (RST),
    .cs_n     (CS_N),
    .swr_n    (SLAVE_WRITE_STROBE_N),
    .ras      (ADDRESS_LATCH_STROBE_IN),
    .rsel     (REGISTER_SELECT_LINES),
    .wdata    (REG_DATA_IN),
    .dma_busy (dma_busy),
    .ack_n    (ACK_N),
    .wr_pulse (REG_WR_PULSE),
    .wr_addr  (REG_WR_ADDR),
    .wr_data  (REG_WR_DATA)
  );

  // Next state of the bus cycle
  always @* begin
    st_nxt = st_r;
    case (st_r)
      S_IDLE: begin
        // local work goes ahead of remote
        if ((loc_act_r & (~LOCAL_TO_MEM | fifo_valid)) | rem_act_r)
          st_nxt = S_REQ;
      end
      S_REQ: begin
        if (!BUS_GRANT)
          st_nxt = S_SLIP;
        else if (WORD32_MODE && first_r)
          st_nxt = S_PRIME;
        else
          st_nxt = S_T1;
      end
      S_SLIP: begin
        if (cnt_r == `HBDI_SLIP_CLKS - 3'h1)
          st_nxt = S_REQ;
      end
      S_PRIME: begin
        if (cnt_r == `HBDI_PRIME_CLKS - 3'h1)
          st_nxt = S_T1;
      end
      S_T1: st_nxt = S_T2;
      S_T2: st_nxt = S_T3;
      S_T3: begin
        st_nxt = EXT_WAIT ? S_TW : S_T4;
      end
      S_TW: st_nxt = EXT_WAIT ? S_TW : S_T4;
      S_T4: begin
        // burst for local, single for remote
        if (is_loc_r && more)
          st_nxt = S_T1;
        else if (is_loc_r)
          st_nxt = S_IDLE;
        else
          st_nxt = S_PWR;
      end
      S_PWR: st_nxt = S_PACK;
      S_PACK: begin
        // drop request after ack high again
        if (rack_low_r && READ_ACK_N)
          st_nxt = S_IDLE;
      end
      default: st_nxt = S_IDLE;
    endcase
  end

  // State, counters and channel bookkeeping
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_r       <= S_IDLE;
      cnt_r      <= 3'h0;
      loc_act_r  <= 1'b0;
      rem_act_r  <= 1'b0;
      is_loc_r   <= 1'b0;
      first_r    <= 1'b1;
      rack_low_r <= 1'b0;
      loc_addr_r <= `HBDI_ADDR_RST;
      rem_addr_r <= `HBDI_ADDR_RST;
      loc_cnt_r  <= 8'h00;
      rem_cnt_r  <= 8'h00;
      rd_data_r  <= `HBDI_DATA_RST;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= (st_nxt == st_r && (st_r == S_SLIP || st_r == S_PRIME)) ?
               cnt_r + 3'h1 : 3'h0;
      if (LOCAL_START && !loc_act_r && LOCAL_COUNT != 8'h00) begin
        loc_act_r  <= 1'b1;
        loc_addr_r <= LOCAL_ADDR;
        loc_cnt_r  <= LOCAL_COUNT;
      end
      if (REMOTE_START && !rem_act_r && REMOTE_COUNT != 8'h00) begin
        rem_act_r  <= 1'b1;
        rem_addr_r <= REMOTE_ADDR;
        rem_cnt_r  <= REMOTE_COUNT;
      end
      if (st_r == S_IDLE && st_nxt == S_REQ) begin
        is_loc_r <= loc_act_r & (~LOCAL_TO_MEM | fifo_valid);
        first_r  <= 1'b1;
      end
      if (st_r == S_T1)
        first_r <= 1'b0;
      if ((st_r == S_T3 || st_r == S_TW) && !EXT_WAIT)
        rd_data_r <= DATA_IN;
      // Step the address once it sits on the bus, so a burst's next T1 sees the new one
      if (st_r == S_T1 && is_loc_r)
        loc_addr_r <= loc_addr_r + step;
      if (st_r == S_T1 && !is_loc_r)
        rem_addr_r <= rem_addr_r + step;
      if (st_r == S_T4 && is_loc_r) begin
        loc_cnt_r  <= loc_cnt_r - 8'h01;
        if (loc_cnt_r == 8'h01)
          loc_act_r <= 1'b0;
      end
      if (st_r == S_PWR)
        rack_low_r <= 1'b0;
      else if (st_r == S_PACK && !READ_ACK_N)
        rack_low_r <= 1'b1;
      if (st_r == S_PACK && st_nxt == S_IDLE) begin
        rem_cnt_r <= rem_cnt_r - 8'h01;
        if (rem_cnt_r == 8'h01)
          rem_act_r <= 1'b0;
      end
    end
  end

  // Bus pins, all from flip-flops
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      BUS_REQUEST_OUT        <= 1'b0;
      ADDRESS_STROBE_OUT     <= 1'b0;
      ADDR_OUT               <= `HBDI_ADDR_RST;
      LOWER_ADDR_OE          <= 1'b0;
      UPPER_ADDRESS_LINES_OE <= 1'b0;
      DATA_OUT               <= `HBDI_DATA_RST;
      DATA_OE                <= 1'b0;
      READ_STROBE_N          <= 1'b1;
      WRITE_STROBE_N         <= 1'b1;
      NET_RD_DATA            <= `HBDI_DATA_RST;
      NET_RD_VALID           <= 1'b0;
      PORT_DATA              <= `HBDI_DATA_RST;
      PORT_WRITE_STROBE_N    <= 1'b1;
      PORT_TRANSFER_REQUEST  <= 1'b0;
    end else begin
      NET_RD_VALID <= 1'b0;
      // Request held from arbitration to end of cycle
      BUS_REQUEST_OUT <= (st_nxt != S_IDLE) && (st_nxt != S_PWR) && (st_nxt != S_PACK);
      // address strobe only in T1 and first primed clock
      ADDRESS_STROBE_OUT <= (st_nxt == S_T1) ||
                            (st_nxt == S_PRIME && st_r != S_PRIME);
      if (st_nxt == S_T1 || st_nxt == S_PRIME)
        ADDR_OUT <= is_loc_r ? loc_addr_r : rem_addr_r;
      LOWER_ADDR_OE <= (st_nxt == S_PRIME) || (st_nxt == S_T1) ||
                       (st_nxt == S_T2) || (st_nxt == S_T3) ||
                       (st_nxt == S_TW) || (st_nxt == S_T4);
      // byte bursts keep upper lines until last
      if (st_nxt == S_T1 || st_nxt == S_PRIME)
        UPPER_ADDRESS_LINES_OE <= 1'b1;
      else if (st_r == S_T4 && !(BYTE_MODE && st_nxt == S_T1))
        UPPER_ADDRESS_LINES_OE <= 1'b0;
      // data strobes after T1, through waits
      READ_STROBE_N  <= ~(~mem_write && (st_nxt == S_T2 || st_nxt == S_T3 ||
                                         st_nxt == S_TW));
      WRITE_STROBE_N <= ~(mem_write && (st_nxt == S_T2 || st_nxt == S_T3 ||
                                        st_nxt == S_TW));
      DATA_OE <= mem_write && (st_nxt == S_T2 || st_nxt == S_T3 ||
                               st_nxt == S_TW || st_nxt == S_T4);
      if (st_nxt == S_T2 && mem_write)
        DATA_OUT <= fifo_data;
      if (st_r == S_T4 && is_loc_r && !LOCAL_TO_MEM) begin
        NET_RD_DATA  <= rd_data_r;
        NET_RD_VALID <= 1'b1;
      end
      if (st_nxt == S_PWR)
        PORT_DATA <= rd_data_r;
      PORT_WRITE_STROBE_N <= ~(st_nxt == S_PWR);
      // request rises after port write strobe
      if (st_r == S_PWR)
        PORT_TRANSFER_REQUEST <= 1'b1;
      else if (st_r == S_PACK && st_nxt == S_IDLE)
        PORT_TRANSFER_REQUEST <= 1'b0;
    end
  end
endmodule // hbdi_top

//--- tb/hbdi_top_asserts.sv
module hbdi_top_asserts (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CS_N,
  input wire logic SLAVE_WRITE_STROBE_N,
  input wire logic ACK_N,
  input wire logic REG_WR_PULSE,
  input wire logic BUS_REQUEST_OUT,
  input wire logic BUS_GRANT,
  input wire logic ADDRESS_STROBE_OUT,
  input wire logic READ_STROBE_N,
  input wire logic WRITE_STROBE_N,
  input wire logic EXT_WAIT,
  input wire logic PORT_WRITE_STROBE_N,
  input wire logic PORT_TRANSFER_REQUEST,
  input wire logic READ_ACK_N
);
  timeunit 1ns;
  timeprecision 1ps;
  wire both_low = !CS_N && !SLAVE_WRITE_STROBE_N;
  wire strb_idle = READ_STROBE_N && WRITE_STROBE_N;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  a_ack_after_sync: assert property ($fell(ACK_N) |-> $past(both_low, 3))
    else $error("ack before sync time");
  a_ack_dma_idle: assert property ($fell(ACK_N) |-> strb_idle)
    else $error("ack during a bus transfer");
  a_ack_release: assert property ((CS_N || SLAVE_WRITE_STROBE_N) |=> ACK_N)
    else $error("ack not released");
  a_pulse_with_ack: assert property (REG_WR_PULSE |-> $fell(ACK_N))
    else $error("write pulse without ack");
  a_grant_start: assert property (
    $rose(BUS_REQUEST_OUT) && BUS_GRANT |=> ADDRESS_STROBE_OUT)
    else $error("no address strobe after grant");
  a_grant_slip: assert property (
    $rose(BUS_REQUEST_OUT) && !BUS_GRANT |=> !ADDRESS_STROBE_OUT [*4])
    else $error("cycle started without slip");
  a_wait_hold: assert property (!strb_idle && EXT_WAIT |=> $stable(strb_idle))
    else $error("strobe ended during wait");
  a_strobe_width: assert property ($fell(strb_idle) |=> !strb_idle)
    else $error("data strobe too short");
  a_port_req_after: assert property (
    $rose(PORT_TRANSFER_REQUEST) |-> $past(!PORT_WRITE_STROBE_N))
    else $error("port request without write strobe");
  a_port_req_drop: assert property (
    PORT_TRANSFER_REQUEST && $rose(READ_ACK_N) |=> !PORT_TRANSFER_REQUEST)
    else $error("port request held after ack");
endmodule // hbdi_top_asserts

bind hbdi_top hbdi_top_asserts u_chk (.*);

//--- tb/hbdi_mem_model.sv
module hbdi_mem_model (
  input  wire logic        CLK,
  input  wire logic        SLOW,
  input  wire logic        BUS_REQUEST_OUT,
  input  wire logic [15:0] ADDR_OUT,
  input  wire logic        READ_STROBE_N,
  input  wire logic        WRITE_STROBE_N,
  input  wire logic        PORT_TRANSFER_REQUEST,
  output logic             BUS_GRANT = 1'b0,
  output logic [31:0]      DATA_IN = 32'h0,
  output logic             EXT_WAIT = 1'b0,
  output logic             READ_ACK_N = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  int lag = 0;
  int waits = 0;
  int gap = 7;
  // arbiter grants at once, or late when slow
  always @(negedge CLK) begin
    lag <= BUS_REQUEST_OUT ? lag + 1 : 0;
    BUS_GRANT <= BUS_REQUEST_OUT && (!SLOW || lag >= 2);
  end
  // memory data valid only under the strobe, at most two waits
  always @(negedge CLK) begin
    DATA_IN <= READ_STROBE_N ? {ADDR_OUT, ~ADDR_OUT} : {~ADDR_OUT, ADDR_OUT};
    waits <= (READ_STROBE_N && WRITE_STROBE_N) ? 0 : waits + EXT_WAIT;
    EXT_WAIT <= SLOW && !(READ_STROBE_N && WRITE_STROBE_N) && waits < 2;
  end
  // port ack pulses spaced at least seven clocks
  always @(negedge CLK) begin
    if (!READ_ACK_N) begin
      READ_ACK_N <= 1'b1;
      gap <= 0;
    end else begin
      gap <= gap + 1;
      if (PORT_TRANSFER_REQUEST && gap >= 7) READ_ACK_N <= 1'b0;
    end
  end
endmodule // hbdi_mem_model

//--- tb/hbdi_test.sv
module hbdi_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK, RST, CS_N, SLAVE_WRITE_STROBE_N, ADDRESS_LATCH_STROBE_IN, BYTE_MODE;
  logic        WORD32_MODE, LOCAL_START, LOCAL_TO_MEM, REMOTE_START, NET_VALID, SLOW;
  logic [3:0]  REGISTER_SELECT_LINES;
  logic [7:0]  REG_DATA_IN, LOCAL_COUNT, REMOTE_COUNT;
  logic [15:0] LOCAL_ADDR, REMOTE_ADDR;
  logic [31:0] NET_DATA;
  wire         ACK_N, REG_WR_PULSE, LOCAL_BUSY, REMOTE_BUSY, NET_READY, NET_RD_VALID;
  wire         BUS_REQUEST_OUT, BUS_GRANT, ADDRESS_STROBE_OUT, LOWER_ADDR_OE, DATA_OE;
  wire         UPPER_ADDRESS_LINES_OE, READ_STROBE_N, WRITE_STROBE_N, EXT_WAIT;
  wire         PORT_WRITE_STROBE_N, PORT_TRANSFER_REQUEST, READ_ACK_N;
  wire [3:0]   REG_WR_ADDR;
  wire [7:0]   REG_WR_DATA;
  wire [15:0]  ADDR_OUT;
  wire [31:0]  NET_RD_DATA, DATA_OUT, DATA_IN, PORT_DATA;
  int          bad_count = 0;
  int          checked = 0;
  int          rcnt = 0;
  int          cyc = 100;
  logic        wprev = 1'b1, rprev = 1'b1, pprev = 1'b1;
  logic [15:0] ea[$];
  logic [31:0] ed[$], er[$], ep[$];

  hbdi_top dut (.*);
  hbdi_mem_model u_mem (.*);

  task automatic close_out();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic fail();
    bad_count++;
    close_out();
  endtask

  // Register write with select before or after strobe, live or latched select
  task automatic reg_write(input logic cs_late, input logic latch, input logic idle);
    logic [3:0] a;
    logic [7:0] d;
    int         n;
    a = $urandom;
    d = $urandom;
    n = 0;
    REGISTER_SELECT_LINES = a;
    REG_DATA_IN = d;
    @(negedge CLK);
    if (latch) begin
      ADDRESS_LATCH_STROBE_IN = 1'b0;
      @(negedge CLK);
      REGISTER_SELECT_LINES = ~a;
    end
    if (cs_late) SLAVE_WRITE_STROBE_N = 1'b0;
    else CS_N = 1'b0;
    repeat (2) @(negedge CLK);
    CS_N = 1'b0;
    SLAVE_WRITE_STROBE_N = 1'b0;
    while (ACK_N !== 1'b0 && n < 400) begin
      @(negedge CLK);
      n++;
    end
    if (n >= 400) fail();
    // With no transfer running, ack on the third edge that sees both low: two sync clocks, then the ack
    if (idle) check(n, 3);
    else check(n > 4, 1);
    check(REG_WR_PULSE, 1);
    check(REG_WR_ADDR, a);
    check(REG_WR_DATA, d);
    SLAVE_WRITE_STROBE_N = 1'b1;
    CS_N = 1'b1;
    @(negedge CLK);
    check(ACK_N, 1);
    ADDRESS_LATCH_STROBE_IN = 1'b1;
    repeat (4) @(negedge CLK);
  endtask

  // One local or remote job; expectations from address, step and count
  task automatic dma(input logic remote, input logic to_mem, input int cnt);
    logic [15:0] a, st, x;
    logic [31:0] w;
    int          n;
    a = $urandom;
    st = BYTE_MODE ? 16'h0001 : (WORD32_MODE ? 16'h0004 : 16'h0002);
    n = 0;
    rcnt = 0;
    for (int i = 0; i < cnt; i++) begin
      x = a + st * i[15:0];
      w = $urandom;
      if (remote) ep.push_back({~x, x});
      else if (!to_mem) er.push_back({~x, x});
      else begin
        ea.push_back(x);
        ed.push_back(w);
        NET_DATA = w;
        NET_VALID = 1'b1;
        while (NET_READY !== 1'b1 && n < 400) begin
          @(negedge CLK);
          n++;
        end
        if (n >= 400) fail();
        @(negedge CLK);
      end
    end
    NET_VALID = 1'b0;
    if (cnt == 16) check(NET_READY, 0);
    {LOCAL_TO_MEM, LOCAL_ADDR, REMOTE_ADDR} = {to_mem, a, a};
    {LOCAL_COUNT, REMOTE_COUNT} = {cnt[7:0], cnt[7:0]};
    if (remote) REMOTE_START = 1'b1;
    else LOCAL_START = 1'b1;
    @(negedge CLK);
    REMOTE_START = 1'b0;
    LOCAL_START = 1'b0;
    cyc = 100;
    n = 0;
    while ((LOCAL_BUSY || REMOTE_BUSY || BUS_REQUEST_OUT ||
            PORT_TRANSFER_REQUEST) && n < 3000) begin
      @(negedge CLK);
      n++;
    end
    if (n >= 3000) fail();
    repeat (4) @(negedge CLK);
    check(ea.size() + ed.size() + er.size() + ep.size(), 0);
    check(UPPER_ADDRESS_LINES_OE, 0);
  endtask

  // Compare every transfer on the memory bus, read port and remote port
  always @(negedge CLK) begin
    cyc++;
    if ((wprev && !WRITE_STROBE_N) || (rprev && !READ_STROBE_N)) begin
      if (LOCAL_BUSY && !SLOW && cyc < 12) check(cyc, 4);
      check(UPPER_ADDRESS_LINES_OE, 1);
      cyc = 0;
      rcnt++;
    end
    if (wprev && !WRITE_STROBE_N) begin
      check(ADDR_OUT, ea.pop_front());
      check(DATA_OUT, ed.pop_front());
    end
    if (pprev && !PORT_WRITE_STROBE_N) begin
      check(PORT_DATA, ep.pop_front());
      check(rcnt, 1);
      rcnt = 0;
    end
    if (NET_RD_VALID) check(NET_RD_DATA, er.pop_front());
    {wprev, rprev, pprev} = {WRITE_STROBE_N, READ_STROBE_N, PORT_WRITE_STROBE_N};
  end

  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  initial begin
    #900000;
    fail();
  end

  // Main sequence
  initial begin
    {RST, CS_N, SLAVE_WRITE_STROBE_N, ADDRESS_LATCH_STROBE_IN} = 4'hF;
    {BYTE_MODE, WORD32_MODE, LOCAL_START, LOCAL_TO_MEM, REMOTE_START, NET_VALID, SLOW} = 7'h00;
    {REGISTER_SELECT_LINES, REG_DATA_IN, LOCAL_COUNT, REMOTE_COUNT} = 28'h0;
    {LOCAL_ADDR, REMOTE_ADDR, NET_DATA} = 64'h0;
    void'($urandom(14));
    repeat (2) @(negedge CLK);
    RST = 1'b0;
    for (int i = 0; i < 4; i++) reg_write(i[0], i[1], 1'b1);
    for (int m = 0; m < 6; m++) begin
      BYTE_MODE = (m % 3 == 0);
      WORD32_MODE = (m % 3 == 2);
      SLOW = (m > 2);
      dma(1'b0, 1'b1, 1 + $urandom % 4);
      dma(1'b0, 1'b0, 1 + $urandom % 4);
      dma(1'b1, 1'b0, 2);
    end
    dma(1'b0, 1'b1, 16);
    fork
      dma(1'b0, 1'b0, 4);
      reg_write(1'b0, 1'b0, 1'b0);
    join
    close_out();
  end
endmodule // hbdi_test
